// *** rtl/fieldbus_slave_event_irq.sv ***
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module fieldbus_slave_event_irq #(
    parameter int GAP_LONG_CYCLES   = fieldbus_slave_event_irq_pkg::GAP_LONG_CYC,
    parameter int TICK_SHORT_CYCLES = fieldbus_slave_event_irq_pkg::TICK_SHORT_CYC
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    output logic             busReady,
    output logic             irqOut,
    output logic             sapsEstablished,
    output logic             offlineState,
    output logic             diagBufSel,
    output logic             syncActive,
    output logic             freezeActive,
    output logic             cmdRejected,
    input  wire logic        jobBusy,
    input  wire logic        diagBusy,
    input  wire logic        dataExchange,
    input  wire logic        baudFound,
    input  wire logic        watchdogExpired,
    input  wire logic        watchdogInControl,
    input  wire logic        gcValid,
    input  wire logic [7:0]  gcByte,
    input  wire logic        telValid,
    input  wire logic [1:0]  telKind,
    input  wire logic [7:0]  telByte,
    input  wire logic        telLast,
    input  wire logic        leaveMaster,
    input  wire logic        globalSync,
    input  wire logic        globalFreeze
);
    fieldbus_slave_event_irq_pkg::state_t st;
    fieldbus_slave_event_irq_pkg::state_t next_st;

    logic [15:0] set;
    logic [15:0] clr;
    logic        msTick;
    logic        active;

    function automatic logic [15:0] kindEvent(input logic [1:0] kind);
        logic [15:0] ev;
        ev = 16'h0000;
        if (kind == fieldbus_slave_event_irq_pkg::KIND_SSA) begin
            ev[fieldbus_slave_event_irq_pkg::EVT_SSA] = 1'b1;
        end else if (kind == fieldbus_slave_event_irq_pkg::KIND_CFG) begin
            ev[fieldbus_slave_event_irq_pkg::EVT_CFG] = 1'b1;
        end else if (kind == fieldbus_slave_event_irq_pkg::KIND_PRM) begin
            ev[fieldbus_slave_event_irq_pkg::EVT_PRM] = 1'b1;
        end else begin
            ev[fieldbus_slave_event_irq_pkg::EVT_OUT] = 1'b1;
        end
        return ev;
    endfunction

    always_comb begin
        next_st = st;
        set = 16'h0000;
        clr = 16'h0000;
        next_st.cmdRejected = 1'b0;
        next_st.busReady = 1'b0;
        next_st.rdata = 16'h0000;

        next_st.exchPrev = dataExchange;
        if (dataExchange != st.exchPrev) begin
            set[fieldbus_slave_event_irq_pkg::EVT_EXCH] = 1'b1;
        end
        if (baudFound) begin
            set[fieldbus_slave_event_irq_pkg::EVT_RATE] = 1'b1;
        end
        if (watchdogExpired && watchdogInControl) begin
            set[fieldbus_slave_event_irq_pkg::EVT_WD] = 1'b1;
        end

        msTick = (st.tickCnt == 16'(TICK_SHORT_CYCLES - 1));
        next_st.tickCnt = msTick ? 16'h0000 : st.tickCnt + 16'h0001;
        if (msTick) begin
            next_st.decade = (st.decade == 4'(fieldbus_slave_event_irq_pkg::
                TICK_LONG_FACTOR - 1)) ? 4'h0 : st.decade + 4'h1;
        end
        if (msTick && (!st.mode[fieldbus_slave_event_irq_pkg::MODE_TICK_LONG]
                || st.decade == 4'(fieldbus_slave_event_irq_pkg::
                TICK_LONG_FACTOR - 1))) begin
            set[fieldbus_slave_event_irq_pkg::EVT_TIMER] = 1'b1;
        end

        if (gcValid && gcByte != st.gcCell) begin
            next_st.gcCell = gcByte;
            set[fieldbus_slave_event_irq_pkg::EVT_GC] = 1'b1;
        end

        if (telValid) begin
            next_st.payload[telKind][st.wrIdx] = telByte;
            next_st.wrIdx = st.wrIdx + 3'h1;
            if (telLast) begin
                next_st.wrIdx = 3'h0;
                set = set | kindEvent(telKind);
            end
        end
        if (leaveMaster) begin
            next_st.payload[fieldbus_slave_event_irq_pkg::KIND_OUT] = '0;
            set[fieldbus_slave_event_irq_pkg::EVT_OUT] = 1'b1;
        end

        if (globalSync) begin
            if (st.mode[fieldbus_slave_event_irq_pkg::MODE_SYNC_OK]) begin
                next_st.syncActive = 1'b1;
            end else begin
                next_st.cmdRejected = 1'b1;
            end
        end
        if (globalFreeze) begin
            if (st.mode[fieldbus_slave_event_irq_pkg::MODE_FREEZE_OK]) begin
                next_st.freezeActive = 1'b1;
            end else begin
                next_st.cmdRejected = 1'b1;
            end
        end

        if (st.offPend && !jobBusy) begin
            next_st.offline = 1'b1;
            next_st.offPend = 1'b0;
            set[fieldbus_slave_event_irq_pkg::EVT_OFFLINE] = 1'b1;
        end
        if (st.diagPend && !diagBusy) begin
            next_st.diagSel = ~st.diagSel;
            next_st.diagPend = 1'b0;
            set[fieldbus_slave_event_irq_pkg::EVT_DIAG] = 1'b1;
        end

        if (st.gapCnt != 16'h0000) begin
            next_st.gapCnt = st.gapCnt - 16'h0001;
        end

        if (st.rdyWait) begin
            next_st.busReady = 1'b1;
            next_st.rdyWait = 1'b0;
        end
        if (wr || rd) begin
            if (st.mode[fieldbus_slave_event_irq_pkg::MODE_EARLY_RDY]) begin
                next_st.busReady = 1'b1;
            end else begin
                next_st.rdyWait = 1'b1;
            end
        end

        if (wr) begin
            if (addr == fieldbus_slave_event_irq_pkg::ADDR_MODE) begin
                next_st.mode = wdata[fieldbus_slave_event_irq_pkg::MODE_W-1:0];
            end else if (addr == fieldbus_slave_event_irq_pkg::ADDR_EN_WORD)
                    begin
                next_st.enable = wdata & fieldbus_slave_event_irq_pkg::EVT_MASK;
            end else if (addr == fieldbus_slave_event_irq_pkg::ADDR_EN_LOW)
                    begin
                next_st.enable[7:0] = wdata[7:0]
                    & fieldbus_slave_event_irq_pkg::EVT_MASK[7:0];
            end else if (addr == fieldbus_slave_event_irq_pkg::ADDR_EN_HIGH)
                    begin
                next_st.enable[15:8] = wdata[7:0]
                    & fieldbus_slave_event_irq_pkg::EVT_MASK[15:8];
            end else if (addr == fieldbus_slave_event_irq_pkg::ADDR_EN_BIT)
                    begin
                next_st.enable[wdata[3:0]] = wdata[4]
                    & fieldbus_slave_event_irq_pkg::EVT_MASK[wdata[3:0]];
            end else if (addr == fieldbus_slave_event_irq_pkg::ADDR_STATUS)
                    begin
                clr = wdata;
            end else if (addr == fieldbus_slave_event_irq_pkg::ADDR_EOI) begin
                next_st.gapCnt = st.mode[fieldbus_slave_event_irq_pkg::MODE_GAP_MS]
                    ? 16'(GAP_LONG_CYCLES)
                    : 16'(fieldbus_slave_event_irq_pkg::GAP_SHORT_CYC);
            end else if (addr == fieldbus_slave_event_irq_pkg::ADDR_CTRL) begin
                if (wdata[fieldbus_slave_event_irq_pkg::CTRL_GO_OFFLINE]) begin
                    next_st.offPend = 1'b1;
                end
                if (wdata[fieldbus_slave_event_irq_pkg::CTRL_GO_ONLINE]) begin
                    next_st.offline = st.offPend && !jobBusy;
                end
                if (wdata[fieldbus_slave_event_irq_pkg::CTRL_NEW_DIAG]) begin
                    next_st.diagPend = 1'b1;
                end
            end
        end

        if (rd) begin
            if (addr == fieldbus_slave_event_irq_pkg::ADDR_MODE) begin
                next_st.rdata = {9'h000, st.mode};
            end else if (addr == fieldbus_slave_event_irq_pkg::ADDR_EN_WORD)
                    begin
                next_st.rdata = st.enable;
            end else if (addr == fieldbus_slave_event_irq_pkg::ADDR_EN_LOW)
                    begin
                next_st.rdata = {8'h00, st.enable[7:0]};
            end else if (addr == fieldbus_slave_event_irq_pkg::ADDR_EN_HIGH)
                    begin
                next_st.rdata = {8'h00, st.enable[15:8]};
            end else if (addr == fieldbus_slave_event_irq_pkg::ADDR_STATUS)
                    begin
                next_st.rdata = st.status;
            end else if (addr == fieldbus_slave_event_irq_pkg::ADDR_CTRL) begin
                next_st.rdata = {10'h000, st.syncActive, st.freezeActive,
                    st.diagPend, st.diagSel, st.offPend, st.offline};
            end else if (addr == fieldbus_slave_event_irq_pkg::ADDR_GC_CELL)
                    begin
                next_st.rdata = {8'h00, st.gcCell};
            end else if (addr[7:6] == fieldbus_slave_event_irq_pkg::BUF_WINDOW)
                    begin
                next_st.rdata = {8'h00, st.payload[addr[4:3]][addr[2:0]]};
            end
        end

        // set wins over clear
        next_st.status = ((st.status & ~clr) | set)
            & fieldbus_slave_event_irq_pkg::EVT_MASK;
        active = (|(next_st.status & next_st.enable))
            && (next_st.gapCnt == 16'h0000);
        next_st.irqOut = next_st.mode[fieldbus_slave_event_irq_pkg::MODE_IRQ_HIGH]
            ? active : ~active;
        next_st.saps = next_st.mode[fieldbus_slave_event_irq_pkg::MODE_SLAVE_PROT];
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.mode <= fieldbus_slave_event_irq_pkg::RST_MODE;
            st.enable <= fieldbus_slave_event_irq_pkg::RST_ENABLE;
            st.status <= fieldbus_slave_event_irq_pkg::RST_STATUS;
            st.irqOut <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign rdata           = st.rdata;
    assign busReady        = st.busReady;
    assign irqOut          = st.irqOut;
    assign sapsEstablished = st.saps;
    assign offlineState    = st.offline;
    assign diagBufSel      = st.diagSel;
    assign syncActive      = st.syncActive;
    assign freezeActive    = st.freezeActive;
    assign cmdRejected     = st.cmdRejected;

    logic irqIdle;
    assign irqIdle = (st.irqOut
        != st.mode[fieldbus_slave_event_irq_pkg::MODE_IRQ_HIGH]);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_ready_normal;
        (wr || rd) && !st.mode[fieldbus_slave_event_irq_pkg::MODE_EARLY_RDY]
        |=> ##1 busReady;
    endproperty
    a_ready_normal: assert property (p_ready_normal)
        else $error("normal ready not two cycles after strobe");

    property p_ready_early;
        (wr || rd) && st.mode[fieldbus_slave_event_irq_pkg::MODE_EARLY_RDY]
        |=> busReady;
    endproperty
    a_ready_early: assert property (p_ready_early)
        else $error("early ready not one cycle after strobe");

    property p_gap_hold;
        wr && addr == fieldbus_slave_event_irq_pkg::ADDR_EOI
        && !$past(wr && addr == fieldbus_slave_event_irq_pkg::ADDR_MODE)
        |=> irqIdle [*8];
    endproperty
    a_gap_hold: assert property (p_gap_hold)
        else $error("interrupt active during inactive time");

    property p_masked_idle;
        (st.status & st.enable) == 16'h0000 |-> irqIdle;
    endproperty
    a_masked_idle: assert property (p_masked_idle)
        else $error("interrupt active with no enabled event");

    property p_irq_on;
        (st.status & st.enable) != 16'h0000 && st.gapCnt == 16'h0000
        |-> !irqIdle;
    endproperty
    a_irq_on: assert property (p_irq_on)
        else $error("pending enabled event without interrupt");

    property p_offline;
        st.offPend && !jobBusy
        |=> offlineState && st.status[fieldbus_slave_event_irq_pkg::EVT_OFFLINE];
    endproperty
    a_offline: assert property (p_offline)
        else $error("offline not entered after job");

    property p_exch;
        $changed(dataExchange)
        |=> st.status[fieldbus_slave_event_irq_pkg::EVT_EXCH];
    endproperty
    a_exch: assert property (p_exch)
        else $error("exchange transition event missing");

    property p_gc;
        gcValid && gcByte != st.gcCell
        |=> st.gcCell == $past(gcByte)
        && st.status[fieldbus_slave_event_irq_pkg::EVT_GC];
    endproperty
    a_gc: assert property (p_gc)
        else $error("global command not stored");

    property p_leave;
        leaveMaster
        |=> st.payload[fieldbus_slave_event_irq_pkg::KIND_OUT] == '0
        && st.status[fieldbus_slave_event_irq_pkg::EVT_OUT];
    endproperty
    a_leave: assert property (p_leave)
        else $error("output buffer not cleared on master leave");

    property p_reject;
        globalSync && !st.mode[fieldbus_slave_event_irq_pkg::MODE_SYNC_OK]
        |=> cmdRejected && syncActive == $past(syncActive);
    endproperty
    a_reject: assert property (p_reject)
        else $error("unsupported sync not rejected");

    c_irq_active: cover property (!irqIdle);
    c_offline: cover property (st.offPend ##[1:20] offlineState);
    c_timer: cover property (st.status[fieldbus_slave_event_irq_pkg::EVT_TIMER]);
    c_gc: cover property (gcValid && gcByte != st.gcCell);
endmodule

// *** rtl/fieldbus_slave_event_irq_pkg.sv ***
package fieldbus_slave_event_irq_pkg;
    // clock and times
    localparam int CLK_NS           = 20;
    localparam int GAP_SHORT_NS     = 1000;
    localparam int GAP_LONG_NS      = 1_000_000;
    localparam int TICK_SHORT_NS    = 1_000_000;
    localparam int TICK_LONG_FACTOR = 10;
    localparam int GAP_SHORT_CYC    = (GAP_SHORT_NS + CLK_NS - 1) / CLK_NS;
    localparam int GAP_LONG_CYC     = (GAP_LONG_NS + CLK_NS - 1) / CLK_NS;
    localparam int TICK_SHORT_CYC   = TICK_SHORT_NS / CLK_NS;

    // register addresses
    localparam logic [7:0] ADDR_MODE     = 8'h00;
    localparam logic [7:0] ADDR_EN_WORD  = 8'h01;
    localparam logic [7:0] ADDR_EN_LOW   = 8'h02;
    localparam logic [7:0] ADDR_EN_HIGH  = 8'h03;
    localparam logic [7:0] ADDR_EN_BIT   = 8'h04;
    localparam logic [7:0] ADDR_STATUS   = 8'h05;
    localparam logic [7:0] ADDR_EOI      = 8'h06;
    localparam logic [7:0] ADDR_CTRL     = 8'h07;
    localparam logic [7:0] ADDR_GC_CELL  = 8'h08;
    localparam logic [1:0] BUF_WINDOW    = 2'h1;

    // hardware option bits
    localparam int MODE_W          = 7;
    localparam int MODE_IRQ_HIGH   = 0;
    localparam int MODE_EARLY_RDY  = 1;
    localparam int MODE_SYNC_OK    = 2;
    localparam int MODE_FREEZE_OK  = 3;
    localparam int MODE_SLAVE_PROT = 4;
    localparam int MODE_GAP_MS     = 5;
    localparam int MODE_TICK_LONG  = 6;
    localparam logic [6:0] RST_MODE = 7'h00;

    // event bits
    localparam int EVT_OFFLINE = 0;
    localparam int EVT_EXCH    = 1;
    localparam int EVT_RATE    = 2;
    localparam int EVT_WD      = 3;
    localparam int EVT_TIMER   = 4;
    localparam int EVT_GC      = 8;
    localparam int EVT_SSA     = 9;
    localparam int EVT_CFG     = 10;
    localparam int EVT_PRM     = 11;
    localparam int EVT_DIAG    = 12;
    localparam int EVT_OUT     = 13;
    localparam logic [15:0] EVT_MASK   = 16'h3F1F;
    localparam logic [15:0] RST_STATUS = 16'h2000;
    localparam logic [15:0] RST_ENABLE = 16'h0000;

    // control bits
    localparam int CTRL_GO_OFFLINE = 0;
    localparam int CTRL_GO_ONLINE  = 1;
    localparam int CTRL_NEW_DIAG   = 2;

    // payload buffers
    localparam int BUF_DEPTH = 8;
    localparam int BUF_IDX_W = 3;
    localparam int BUF_KINDS = 4;
    localparam logic [1:0] KIND_SSA = 2'h0;
    localparam logic [1:0] KIND_CFG = 2'h1;
    localparam logic [1:0] KIND_PRM = 2'h2;
    localparam logic [1:0] KIND_OUT = 2'h3;

    typedef struct packed {
        logic [MODE_W-1:0]                        mode;
        logic [15:0]                              enable;
        logic [15:0]                              status;
        logic [7:0]                               gcCell;
        logic [BUF_KINDS-1:0][BUF_DEPTH-1:0][7:0] payload;
        logic [BUF_IDX_W-1:0]                     wrIdx;
        logic                                     exchPrev;
        logic                                     offPend;
        logic                                     offline;
        logic                                     diagPend;
        logic                                     diagSel;
        logic                                     syncActive;
        logic                                     freezeActive;
        logic                                     cmdRejected;
        logic [15:0]                              gapCnt;
        logic [15:0]                              tickCnt;
        logic [3:0]                               decade;
        logic                                     rdyWait;
        logic                                     busReady;
        logic                                     irqOut;
        logic                                     saps;
        logic [15:0]                              rdata;
    } state_t;
endpackage

// *** test/fieldbus_host_model.sv ***
`timescale 1ns/1ps
module fieldbus_host_model (
    input  wire logic        sys_clk,
    output logic             rst_n,
    output logic      [7:0]  addr,
    output logic      [15:0] wdata,
    output logic             wr,
    output logic             rd,
    input  wire logic [15:0] rdata,
    input  wire logic        busReady
);
    logic rdy1;
    logic rdy2;
    initial begin
        rst_n = 1'b0;
        addr = 8'h00;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
    end
    task automatic doReset();
        rst_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
    endtask
    task automatic wrReg(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
        wdata <= ~d;
    endtask
    task automatic rdReg(input logic [7:0] a, output logic [15:0] v);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        v = rdata;
        rdy1 = busReady;
        @(posedge sys_clk);
        #1;
        rdy2 = busReady;
    endtask
endmodule

// *** test/fieldbus_slave_event_irq_tb_top.sv ***
`timescale 1ns/1ps
module fieldbus_slave_event_irq_tb_top;
    localparam int GAPL = 100;
    localparam int TICK = 60;
    localparam logic [7:0] aMode = fieldbus_slave_event_irq_pkg::ADDR_MODE;
    localparam logic [7:0] aEnW = fieldbus_slave_event_irq_pkg::ADDR_EN_WORD;
    localparam logic [7:0] aEnL = fieldbus_slave_event_irq_pkg::ADDR_EN_LOW;
    localparam logic [7:0] aEnH = fieldbus_slave_event_irq_pkg::ADDR_EN_HIGH;
    localparam logic [7:0] aEnB = fieldbus_slave_event_irq_pkg::ADDR_EN_BIT;
    localparam logic [7:0] aSt = fieldbus_slave_event_irq_pkg::ADDR_STATUS;
    localparam logic [7:0] aEoi = fieldbus_slave_event_irq_pkg::ADDR_EOI;
    localparam logic [7:0] aCtl = fieldbus_slave_event_irq_pkg::ADDR_CTRL;
    localparam logic [7:0] aGc = fieldbus_slave_event_irq_pkg::ADDR_GC_CELL;
    logic sys_clk = 1'b0;
    logic rst_n, wr, rd, busReady, irqOut, saps, offlineState, diagBufSel;
    logic syncActive, freezeActive, cmdRejected, jobBusy, diagBusy;
    logic dataExchange, baudFound, wdExp, wdCtl, gcValid, telValid, telLast;
    logic leaveMaster, globalSync, globalFreeze, s;
    logic [7:0] addr, gcByte, telByte;
    logic [15:0] wdata, rdata, v;
    logic [1:0] telKind;
    logic [15:0] kindEvt [4] = '{16'h0200, 16'h0400, 16'h0800, 16'h2000};
    int errTotal = 0;
    int checkCount = 0;
    int n;
    time t0;
    always #10 sys_clk = ~sys_clk;
    fieldbus_host_model host (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .busReady(busReady));
    fieldbus_slave_event_irq #(.GAP_LONG_CYCLES(GAPL),
        .TICK_SHORT_CYCLES(TICK)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .busReady(busReady), .irqOut(irqOut), .sapsEstablished(saps),
        .offlineState(offlineState), .diagBufSel(diagBufSel),
        .syncActive(syncActive), .freezeActive(freezeActive),
        .cmdRejected(cmdRejected), .jobBusy(jobBusy), .diagBusy(diagBusy),
        .dataExchange(dataExchange), .baudFound(baudFound),
        .watchdogExpired(wdExp), .watchdogInControl(wdCtl),
        .gcValid(gcValid), .gcByte(gcByte), .telValid(telValid),
        .telKind(telKind), .telByte(telByte), .telLast(telLast),
        .leaveMaster(leaveMaster), .globalSync(globalSync),
        .globalFreeze(globalFreeze));
    task automatic endOfTest();
        $display("checks %0d mismatches %0d", checkCount, errTotal);
        if (errTotal == 0 && checkCount > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checkCount++;
        if (g !== e) begin
            errTotal++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic stat(input logic [15:0] e);
        host.rdReg(aSt, v);
        chk(v & 16'hFFEF, e);
        host.wrReg(aSt, 16'hFFFF);
    endtask
    task automatic waitIrq(input logic lvl, input int lim);
        n = 0;
        while (irqOut !== lvl) begin
            if (n == lim) begin
                chk({15'h0000, irqOut}, {15'h0000, lvl});
                endOfTest();
            end
            @(posedge sys_clk);
            #1;
            n++;
        end
    endtask
    task automatic period(input int lo, input int hi, input logic clrTick);
        t0 = $time;
        if (clrTick) begin
            host.wrReg(aSt, 16'h0010);
            waitIrq(1'b1, 5);
        end
        waitIrq(1'b0, hi + 5);
        n = int'(($time - t0) / 20);
        chk({15'h0000, n >= lo && n <= hi}, 16'h0001);
    endtask
    initial begin
        {jobBusy, diagBusy, dataExchange, baudFound, wdExp, wdCtl} = 6'h00;
        {gcValid, telValid, telLast, leaveMaster, globalSync} = 5'h00;
        {globalFreeze, gcByte, telByte, telKind} = 19'h0_0000;
        host.doReset();
        chk({15'h0000, irqOut}, 16'h0001);
        chk({15'h0000, saps}, 16'h0000);
        stat(16'h2000);
        host.wrReg(aEnW, 16'hFFFF);
        host.rdReg(aEnW, v);
        chk(v, 16'h3F1F);
        host.wrReg(aEnL, 16'h0000);
        host.rdReg(aEnW, v);
        chk(v, 16'h3F00);
        host.wrReg(aEnB, 16'h000D);
        host.rdReg(aEnW, v);
        chk(v, 16'h1F00);
        host.wrReg(aEnH, 16'h0000);
        host.rdReg(aEnW, v);
        chk(v, 16'h0000);
        chk({14'h0000, host.rdy1, host.rdy2}, 16'h0001);
        host.wrReg(aMode, 16'h0012);
        host.rdReg(aMode, v);
        chk(v, 16'h0012);
        chk({14'h0000, host.rdy1, host.rdy2}, 16'h0002);
        chk({15'h0000, saps}, 16'h0001);
        $display("test options done");
        for (int k = 0; k < 4; k++) begin
            @(posedge sys_clk);
            {telValid, telLast, telKind, telByte} <= {2'b10, 2'(k), 8'(16 + k)};
            @(posedge sys_clk);
            {telLast, telByte} <= {1'b1, 8'(192 + k)};
            @(posedge sys_clk);
            {telValid, telLast} <= 2'b00;
            stat(kindEvt[k]);
            host.rdReg(8'(64 + 8 * k), v);
            chk(v, 16'(16 + k));
            host.rdReg(8'(65 + 8 * k), v);
            chk(v, 16'(192 + k));
        end
        @(posedge sys_clk) leaveMaster <= 1'b1;
        @(posedge sys_clk) leaveMaster <= 1'b0;
        stat(16'h2000);
        host.rdReg(8'h58, v);
        chk(v, 16'h0000);
        for (int k = 0; k < 2; k++) begin
            @(posedge sys_clk) {gcValid, gcByte} <= {1'b1, 8'hA5};
            @(posedge sys_clk) gcValid <= 1'b0;
            stat(k == 0 ? 16'h0100 : 16'h0000);
            host.rdReg(aGc, v);
            chk(v, 16'h00A5);
        end
        $display("test telegrams done");
        for (int k = 0; k < 2; k++) begin
            @(posedge sys_clk) dataExchange <= ~dataExchange;
            stat(16'h0002);
        end
        @(posedge sys_clk) baudFound <= 1'b1;
        @(posedge sys_clk) baudFound <= 1'b0;
        stat(16'h0004);
        for (int k = 0; k < 2; k++) begin
            @(posedge sys_clk) {wdExp, wdCtl} <= {1'b1, 1'(k)};
            @(posedge sys_clk) wdExp <= 1'b0;
            stat(k == 1 ? 16'h0008 : 16'h0000);
        end
        jobBusy <= 1'b1;
        host.wrReg(aCtl, 16'h0001);
        repeat (5) @(posedge sys_clk);
        #1 chk({15'h0000, offlineState}, 16'h0000);
        @(posedge sys_clk) jobBusy <= 1'b0;
        repeat (4) @(posedge sys_clk);
        #1 chk({15'h0000, offlineState}, 16'h0001);
        stat(16'h0001);
        s = diagBufSel;
        host.wrReg(aCtl, 16'h0004);
        repeat (3) @(posedge sys_clk);
        #1 chk({15'h0000, diagBufSel}, {15'h0000, ~s});
        stat(16'h1000);
        @(posedge sys_clk) {globalSync, globalFreeze} <= 2'b11;
        @(posedge sys_clk) {globalSync, globalFreeze} <= 2'b00;
        #1 s = cmdRejected;
        @(posedge sys_clk);
        #1 chk({12'h000, s, cmdRejected, syncActive, freezeActive},
            16'h0008);
        host.wrReg(aMode, 16'h001E);
        @(posedge sys_clk) {globalSync, globalFreeze} <= 2'b11;
        @(posedge sys_clk) {globalSync, globalFreeze} <= 2'b00;
        repeat (2) @(posedge sys_clk);
        #1 chk({14'h0000, syncActive, freezeActive}, 16'h0003);
        $display("test events done");
        host.wrReg(aMode, 16'h0012);
        host.wrReg(aSt, 16'hFFFF);
        s = 1'b1;
        repeat (130) @(negedge sys_clk) s = s & irqOut;
        chk({15'h0000, s}, 16'h0001);
        host.rdReg(aSt, v);
        chk(v & 16'h0010, 16'h0010);
        host.wrReg(aEnW, 16'h0010);
        host.wrReg(aSt, 16'h0010);
        waitIrq(1'b1, 5);
        waitIrq(1'b0, TICK + 5);
        period(TICK - 1, TICK + 1, 1'b1);
        host.wrReg(aMode, 16'h0052);
        host.wrReg(aSt, 16'h0010);
        waitIrq(1'b1, 5);
        waitIrq(1'b0, 10 * TICK + 5);
        period(10 * TICK - 1, 10 * TICK + 1, 1'b1);
        host.wrReg(aEoi, 16'h0000);
        waitIrq(1'b1, 5);
        period(48, 52, 1'b0);
        host.wrReg(aMode, 16'h0072);
        host.wrReg(aEoi, 16'h0000);
        waitIrq(1'b1, 5);
        period(GAPL - 2, GAPL + 2, 1'b0);
        host.wrReg(aMode, 16'h0013);
        repeat (2) @(posedge sys_clk);
        #1 chk({15'h0000, irqOut}, 16'h0001);
        host.wrReg(aEnW, 16'h0000);
        repeat (2) @(posedge sys_clk);
        #1 chk({15'h0000, irqOut}, 16'h0000);
        $display("test interrupt done");
        endOfTest();
    end
endmodule
